// File: hdl/eis_defines.svh
// Constants for the two-wire serial memory slave front end and its master
`ifndef EIS_DEFINES_SVH
`define EIS_DEFINES_SVH
// Clock period in ps (200 MHz)
`define EIS_CLK_PS 5000
// Glitch width in ns and its cycle count (longest, rounds down)
`define EIS_GLITCH_NS 50
`define EIS_GLITCH_CYC ((`EIS_GLITCH_NS * 1000) / `EIS_CLK_PS)
// Power-up ready delay in us and cycle count (longest, rounds down)
`define EIS_PWRUP_US 350
`define EIS_PWRUP_CYC ((`EIS_PWRUP_US * 1000000) / `EIS_CLK_PS)
// Internal write time in us and cycle count (longest, rounds down)
`define EIS_WRITE_US 4000
`define EIS_WRITE_CYC ((`EIS_WRITE_US * 1000) / (`EIS_CLK_PS / 1000))
// Device-type code, arbitrary value
`define EIS_TYPE_CODE 4'h5
// Master clock divider: half period in cycles (80 ns)
`define EIS_HALF_CYC 16
// Address bytes after a write-direction slave address
`define EIS_ADDR_BYTES 2
`endif

// File: hdl/eis_if.sv
// Two-wire bus between the master and the slave front end
`timescale 1ns/1ps
interface eis_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Open-drain wired-and with pull-ups
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
        output sda_m_o, output sda_m_oe);
endinterface

// File: hdl/eis_master.sv
// Bus master end: drives clock and runs one byte transaction per order
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_master (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    eis_if.master bus,
    // User orders
    input wire logic go_i,
    input wire logic [7:0] byte_i,
    input wire logic last_i,
    input wire logic rd_i,
    input wire logic send_start_i,
    output logic [7:0] byte_o,
    output logic acked_o,
    output logic done_o,
    output logic busy_o
);
    ////////////////////////////////////////////////////////////////////
    // Divider pulse for clock half periods
    logic [4:0] div_r;
    logic tick;
    assign tick = div_r == 5'(`EIS_HALF_CYC - 1);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= 5'h0;
        end else if (tick || !busy_o) begin
            div_r <= 5'h0;
        end else begin
            div_r <= div_r + 5'h1;
        end
    end

    // Sampled data line, three flops, only the last flop is used
    logic [2:0] sda_s_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_s_r <= 3'h7;
        end else begin
            sda_s_r <= {sda_s_r[1:0], bus.sda};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Byte sequencer: phase 0 clock low, phase 1 clock high
    eis_pkg::eis_mstate_t st_r;
    logic [7:0] sh_r;
    logic [7:0] rx_r;      // Bits read back, taken late in each high phase
    logic [3:0] bit_r;
    logic ph_r;
    logic rd_r;
    logic last_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= eis_pkg::EIS_M_IDLE;
            sh_r <= 8'h0;
            rx_r <= 8'h0;
            bit_r <= 4'h0;
            ph_r <= 1'h0;
            rd_r <= 1'h0;
            last_r <= 1'h0;
            bus.scl_o <= 1'h1;
            bus.scl_oe <= 1'h0;
            bus.sda_m_o <= 1'h1;
            bus.sda_m_oe <= 1'h0;
            byte_o <= 8'h0;
            acked_o <= 1'h0;
            done_o <= 1'h0;
            busy_o <= 1'h0;
        end else begin
            done_o <= 1'h0;
            unique case (st_r)
                eis_pkg::EIS_M_IDLE: begin
                    if (go_i) begin
                        busy_o <= 1'h1;
                        sh_r <= byte_i;
                        rd_r <= rd_i;
                        last_r <= last_i;
                        bit_r <= 4'h0;
                        ph_r <= 1'h0;
                        st_r <= send_start_i ? eis_pkg::EIS_M_START
                            : eis_pkg::EIS_M_BIT;
                    end
                end
                eis_pkg::EIS_M_START: if (tick) begin
                    // Release both, then pull data low with clock high
                    ph_r <= !ph_r;
                    if (!ph_r) begin
                        bus.sda_m_oe <= 1'h0;
                        bus.scl_oe <= 1'h0;
                    end else begin
                        bus.sda_m_o <= 1'h0;
                        bus.sda_m_oe <= 1'h1;
                        st_r <= eis_pkg::EIS_M_BIT;
                    end
                end
                eis_pkg::EIS_M_BIT: if (tick) begin
                    ph_r <= !ph_r;
                    if (!ph_r) begin
                        // Clock low and change data on the same tick
                        bus.scl_o <= 1'h0;
                        bus.scl_oe <= 1'h1;
                        bus.sda_m_o <= 1'h0;
                        bus.sda_m_oe <= !rd_r && !sh_r[7];
                        // Previous bit taken at the end of its high phase
                        if (bit_r != 4'h0) begin
                            rx_r <= {rx_r[6:0], sda_s_r[2]};
                        end
                    end else begin
                        bus.scl_oe <= 1'h0;
                        sh_r <= {sh_r[6:0], 1'h1};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h7) begin
                            st_r <= eis_pkg::EIS_M_ACK;
                        end
                    end
                end
                eis_pkg::EIS_M_ACK: if (tick) begin
                    if (bit_r == 4'h9) begin
                        // Slave answers late after our edge, so look late
                        acked_o <= rd_r ? !last_r : !sda_s_r[2];
                        byte_o <= rx_r;
                        st_r <= last_r || (!rd_r && sda_s_r[2])
                            ? eis_pkg::EIS_M_STOP : eis_pkg::EIS_M_DONE;
                    end else begin
                        ph_r <= !ph_r;
                        if (!ph_r) begin
                            bus.scl_oe <= 1'h1;
                            rx_r <= {rx_r[6:0], sda_s_r[2]};
                            // Ack a read byte unless the last
                            bus.sda_m_o <= 1'h0;
                            bus.sda_m_oe <= rd_r && !last_r;
                        end else begin
                            bus.scl_oe <= 1'h0;
                            bit_r <= 4'h9;
                        end
                    end
                end
                eis_pkg::EIS_M_STOP: if (tick) begin
                    // Data low under low clock, then rise with clock high
                    ph_r <= !ph_r;
                    if (!ph_r) begin
                        bus.scl_oe <= 1'h1;
                        bus.sda_m_o <= 1'h0;
                        bus.sda_m_oe <= 1'h1;
                    end else begin
                        bus.scl_oe <= 1'h0;
                        st_r <= eis_pkg::EIS_M_DONE;
                    end
                end
                eis_pkg::EIS_M_DONE: if (tick) begin
                    // Release data; a read ack stays low, no false stop
                    if (!rd_r || last_r) begin
                        bus.sda_m_oe <= 1'h0;
                    end
                    done_o <= 1'h1;
                    busy_o <= 1'h0;
                    ph_r <= 1'h0;
                    st_r <= eis_pkg::EIS_M_IDLE;
                end
                default: st_r <= eis_pkg::EIS_M_IDLE;
            endcase
        end
    end
endmodule // eis_master

// File: hdl/eis_pkg.sv
// Types shared by both ends of the serial memory link
package eis_pkg;
    typedef enum logic [2:0] {
        EIS_IDLE = 3'h0,
        EIS_RX = 3'h1,
        EIS_RACK = 3'h2,
        EIS_TX = 3'h3,
        EIS_TACK = 3'h4
    } eis_state_t;
    typedef enum logic [2:0] {
        EIS_M_IDLE = 3'h0,
        EIS_M_START = 3'h1,
        EIS_M_BIT = 3'h2,
        EIS_M_ACK = 3'h3,
        EIS_M_STOP = 3'h4,
        EIS_M_DONE = 3'h5
    } eis_mstate_t;
endpackage

// File: hdl/eis_slave.sv
// Slave front end of a small serial memory
//
// Overview of operation
// - Slave only, never drives the clock
// - Master makes clock; direction picks data driver
// - START is SDA fall, clock high
// - STOP is SDA rise, ends command
// - Data stable while clock is high
// - Master starts only on idle bus
// - Sample on rising, change on falling
// - Open-drain data: low drives, one releases
// - Address: type code, three selects, direction
// - Respond only when selects match straps
// - Last address bit one means read
// - Transmitter releases data on ninth clock
// - Receiver acks low, nack leaves high
// - Floating strap reads low
// - Protect high blocks every memory write (code blocks only by protect as taken at the second address byte)
// - Power-on reset forces reset state
// - Ready within power-up delay
// - Glitches up to 50 ns ignored
// - Two address bytes follow write address
// - STOP after write starts write cycle
// - No address ack during write cycle
// - Protect at first data rejects byte (code decides by protect as taken at the second address byte)
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_slave #(
    parameter int unsigned PWRUP_CYC = `EIS_PWRUP_CYC,
    parameter int unsigned WRITE_CYC = `EIS_WRITE_CYC
) (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    eis_if.slave bus,
    // Straps and protect, pulled low outside when floating
    input wire logic [2:0] chip_select_i,
    input wire logic write_protect_i,
    // Memory side
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic [7:0] tx_data_i,
    output logic tx_req_o,
    output logic [15:0] mem_addr_o,
    output logic write_start_o,
    output logic ready_o,
    output logic busy_o
);
    localparam int unsigned GW = `EIS_GLITCH_CYC;

    ////////////////////////////////////////////////////////////////////
    // Three-flop synchronisers; the first flop feeds only the second
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
        end else begin
            scl_s_r <= {scl_s_r[1:0], bus.scl};
            sda_s_r <= {sda_s_r[1:0], bus.sda};
        end
    end

    // Glitch filters: a level must hold past the glitch width
    logic scl_f_r;
    logic sda_f_r;
    logic [4:0] scl_cnt_r;
    logic [4:0] sda_cnt_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_f_r <= 1'h1;
            scl_cnt_r <= 5'h0;
        end else if (scl_s_r[2] != scl_s_r[1] || scl_s_r[2] == scl_f_r) begin
            scl_cnt_r <= 5'h0;
        end else if (scl_cnt_r == 5'(GW)) begin
            scl_f_r <= scl_s_r[2];
            scl_cnt_r <= 5'h0;
        end else begin
            scl_cnt_r <= scl_cnt_r + 5'h1;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_f_r <= 1'h1;
            sda_cnt_r <= 5'h0;
        end else if (sda_s_r[2] != sda_s_r[1] || sda_s_r[2] == sda_f_r) begin
            sda_cnt_r <= 5'h0;
        end else if (sda_cnt_r == 5'(GW)) begin
            sda_f_r <= sda_s_r[2];
            sda_cnt_r <= 5'h0;
        end else begin
            sda_cnt_r <= sda_cnt_r + 5'h1;
        end
    end

    // Edge and condition detection on filtered lines
    logic scl_d_r;
    logic sda_d_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_d_r <= 1'h1;
            sda_d_r <= 1'h1;
        end else begin
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_f_r;
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_f_r && !scl_d_r;
    assign scl_fall = !scl_f_r && scl_d_r;
    assign start_det = scl_f_r && scl_d_r && sda_d_r && !sda_f_r;
    assign stop_det = scl_f_r && scl_d_r && !sda_d_r && sda_f_r;

    ////////////////////////////////////////////////////////////////////
    // Power-up delay and internal write timer
    logic [31:0] pu_cnt_r;
    logic [31:0] wr_cnt_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pu_cnt_r <= 32'h0;
            ready_o <= 1'h0;
        end else if (pu_cnt_r == PWRUP_CYC - 1) begin
            ready_o <= 1'h1;
        end else begin
            pu_cnt_r <= pu_cnt_r + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Byte engine
    eis_pkg::eis_state_t st_r;
    logic [7:0] sh_r;
    logic [3:0] bit_r;
    logic [1:0] byte_r;    // Bytes acked since START, slave address included, saturating
    logic is_read_r;
    logic wr_ok_r;         // Write session still accepted
    logic wr_pend_r;       // Data byte accepted since the last STOP
    logic ack_r;           // Current ninth-clock answer
    logic wp_r;            // Protect sampled before first data byte

    logic addr_match;
    assign addr_match = sh_r[7:4] == `EIS_TYPE_CODE
        && sh_r[3:1] == chip_select_i
        && !busy_o;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= eis_pkg::EIS_IDLE;
            sh_r <= 8'h0;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            is_read_r <= 1'h0;
            wr_ok_r <= 1'h0;
            wr_pend_r <= 1'h0;
            ack_r <= 1'h0;
            wp_r <= 1'h0;
            bus.sda_s_o <= 1'h1;
            bus.sda_s_oe <= 1'h0;
            rx_data_o <= 8'h0;
            rx_valid_o <= 1'h0;
            tx_req_o <= 1'h0;
            mem_addr_o <= 16'h0;
            write_start_o <= 1'h0;
            busy_o <= 1'h0;
            wr_cnt_r <= 32'h0;
        end else begin
            rx_valid_o <= 1'h0;
            tx_req_o <= 1'h0;
            write_start_o <= 1'h0;
            // Write cycle timer
            if (busy_o) begin
                if (wr_cnt_r == WRITE_CYC - 1) begin
                    busy_o <= 1'h0;
                end
                wr_cnt_r <= wr_cnt_r + 32'h1;
            end
            if (!ready_o) begin
                st_r <= eis_pkg::EIS_IDLE;
            end else if (stop_det) begin
                st_r <= eis_pkg::EIS_IDLE;
                bus.sda_s_oe <= 1'h0;
                if (wr_pend_r && wr_ok_r) begin
                    busy_o <= 1'h1;
                    wr_cnt_r <= 32'h0;
                    write_start_o <= 1'h1;
                end
                wr_pend_r <= 1'h0;
            end else if (start_det) begin
                // Repeated START keeps a pending write address
                st_r <= eis_pkg::EIS_RX;
                bit_r <= 4'h0;
                byte_r <= 2'h0;
                is_read_r <= 1'h0;
                bus.sda_s_oe <= 1'h0;
            end else begin
                unique case (st_r)
                    eis_pkg::EIS_IDLE: begin
                        bus.sda_s_oe <= 1'h0;
                    end
                    eis_pkg::EIS_RX: begin
                        if (scl_rise) begin
                            sh_r <= {sh_r[6:0], sda_f_r};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall && bit_r == 4'h8) begin
                            bit_r <= 4'h0;
                            st_r <= eis_pkg::EIS_RACK;
                            ack_r <= 1'h0;
                            if (byte_r == 2'h0) begin
                                ack_r <= addr_match;
                                is_read_r <= sh_r[0];
                                wr_ok_r <= !sh_r[0];
                            end else if (byte_r <= 2'(`EIS_ADDR_BYTES)) begin
                                ack_r <= 1'h1;
                                if (byte_r == 2'h1) begin
                                    mem_addr_o[15:8] <= sh_r;
                                end else begin
                                    mem_addr_o[7:0] <= sh_r;
                                end
                                wp_r <= write_protect_i;
                            end else begin
                                ack_r <= wr_ok_r && !wp_r;
                                if (wr_ok_r && !wp_r) begin
                                    rx_data_o <= sh_r;
                                    rx_valid_o <= 1'h1;
                                    wr_pend_r <= 1'h1;
                                end else begin
                                    wr_ok_r <= 1'h0;
                                end
                            end
                            // Pull low only to acknowledge
                            bus.sda_s_o <= 1'h0;
                            bus.sda_s_oe <= (byte_r == 2'h0) ? addr_match
                                : (byte_r <= 2'(`EIS_ADDR_BYTES)) ? 1'h1
                                : wr_ok_r && !wp_r;
                        end
                    end
                    eis_pkg::EIS_RACK: begin
                        if (scl_fall) begin
                            bus.sda_s_oe <= 1'h0;
                            if (!ack_r) begin
                                st_r <= eis_pkg::EIS_IDLE;
                            end else begin
                                if (byte_r != 2'h3) begin
                                    byte_r <= byte_r + 2'h1;
                                end
                                if (byte_r == 2'h0 && is_read_r) begin
                                    st_r <= eis_pkg::EIS_TX;
                                    sh_r <= {tx_data_i[6:0], 1'h1};
                                    bus.sda_s_o <= tx_data_i[7];
                                    bus.sda_s_oe <= !tx_data_i[7];
                                    tx_req_o <= 1'h1;
                                    bit_r <= 4'h1;
                                end else begin
                                    st_r <= eis_pkg::EIS_RX;
                                end
                            end
                        end
                    end
                    eis_pkg::EIS_TX: begin
                        if (scl_fall) begin
                            if (bit_r == 4'h8) begin
                                bus.sda_s_oe <= 1'h0;
                                st_r <= eis_pkg::EIS_TACK;
                            end else begin
                                bus.sda_s_o <= sh_r[7];
                                bus.sda_s_oe <= !sh_r[7];
                                sh_r <= {sh_r[6:0], 1'h1};
                                bit_r <= bit_r + 4'h1;
                            end
                        end
                    end
                    eis_pkg::EIS_TACK: begin
                        if (scl_rise) begin
                            ack_r <= !sda_f_r;
                        end else if (scl_fall) begin
                            if (ack_r) begin
                                st_r <= eis_pkg::EIS_TX;
                                sh_r <= {tx_data_i[6:0], 1'h1};
                                bus.sda_s_o <= tx_data_i[7];
                                bus.sda_s_oe <= !tx_data_i[7];
                                tx_req_o <= 1'h1;
                                bit_r <= 4'h1;
                            end else begin
                                st_r <= eis_pkg::EIS_IDLE;
                            end
                        end
                    end
                    default: st_r <= eis_pkg::EIS_IDLE;
                endcase
            end
        end
    end
    // Clock line is never driven from this end
endmodule // eis_slave

// File: test/eeprom_i2c_slave_front_end_bench.sv
// Self-checking bench: master and slave ends joined on one link
`timescale 1ns/1ps
`include "eis_defines.svh"
module eeprom_i2c_slave_front_end_bench;
    // Short write cycle keeps polling cheap
    localparam int WR_CYC = 2000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic go = 1'b0, lst = 1'b0, rd = 1'b0, st = 1'b0, wp = 1'b0;
    logic [2:0] cs = 3'h0;
    logic [7:0] bin = 8'h00, txd = 8'h00, adr, bout, rxd;
    logic acked, done, mbusy, rxv, txreq, wst, ready, sbusy, ak;
    logic [15:0] maddr;
    int err_total = 0, n_compared = 0, seed = 30;
    int cyc = 0, t_wr = 0, n_wr = 0, n_tx = 0, k;
    logic [7:0] rx_q[$];
    eis_if eis_if_i ();
    eis_slave #(.PWRUP_CYC(50), .WRITE_CYC(WR_CYC)) eis_slave_i (
        .clk_i(clk_i), .rst_i(rst_i), .bus(eis_if_i), .chip_select_i(cs),
        .write_protect_i(wp), .rx_data_o(rxd), .rx_valid_o(rxv),
        .tx_data_i(txd), .tx_req_o(txreq), .mem_addr_o(maddr),
        .write_start_o(wst), .ready_o(ready), .busy_o(sbusy));
    eis_master eis_master_i (.clk_i(clk_i), .rst_i(rst_i), .bus(eis_if_i),
        .go_i(go), .byte_i(bin), .last_i(lst), .rd_i(rd), .send_start_i(st),
        .byte_o(bout), .acked_o(acked), .done_o(done), .busy_o(mbusy));
    eis_monitor eis_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
        .scl_o(eis_if_i.scl_o), .scl_oe(eis_if_i.scl_oe),
        .sda_m_o(eis_if_i.sda_m_o), .sda_m_oe(eis_if_i.sda_m_oe),
        .sda_s_o(eis_if_i.sda_s_o), .sda_s_oe(eis_if_i.sda_s_oe),
        .scl(eis_if_i.scl), .sda(eis_if_i.sda));
    ////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One edge of a bounded wait; a hang ends the run
    task automatic tick(inout int n);
        @(posedge clk_i);
        #1;
        n++;
        if (n > 4000) begin
            err_total++;
            print_verdict();
        end
    endtask
    // One byte order to the master, ack seen on the ninth clock
    task automatic xfer(input logic [7:0] b, input logic s, l, r);
        int n;
        n = 0;
        while (mbusy !== 1'b0) tick(n);
        @(posedge clk_i);
        go <= 1'b1;
        bin <= b;
        st <= s;
        lst <= l;
        rd <= r;
        @(posedge clk_i);
        go <= 1'b0;
        do tick(n); while (done !== 1'b1);
        ak = acked;
    endtask
    // Model of the memory side: queued bytes and write launches
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rxv === 1'b1) begin
            check(rxd, (rx_q.size() > 0) ? rx_q.pop_front() : 9'h100);
        end
        if (txreq === 1'b1) begin
            n_tx <= n_tx + 1;
        end
        if (wst === 1'b1) begin
            n_wr <= n_wr + 1;
            t_wr <= cyc;
        end
    end
    // Write: slave address, two address bytes, one data byte, stop
    task automatic wseq(input logic p);
        logic [7:0] hi, lo, d;
        hi = 8'($random(seed));
        lo = 8'($random(seed));
        d = 8'($random(seed));
        xfer(adr, 1'b1, 1'b0, 1'b0);
        check(ak, 1'b1);
        xfer(hi, 1'b0, 1'b0, 1'b0);
        check(ak, 1'b1);
        xfer(lo, 1'b0, 1'b0, 1'b0);
        check(ak, 1'b1);
        check(maddr, {hi, lo});
        if (!p) rx_q.push_back(d);
        xfer(d, 1'b0, 1'b1, 1'b0);
        check(ak, !p);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        cs <= 3'($random(seed));
        txd <= 8'($random(seed));
        rst_i <= 1'b0;
        tick(k);
        adr = {`EIS_TYPE_CODE, cs, 1'b0};
        check(ready, 1'b0);
        k = 0;
        while (ready !== 1'b1) tick(k);
        check(k <= 50, 1'b1);
        // Every strap value; only our own is answered
        for (int i = 0; i < 8; i++) begin
            xfer({`EIS_TYPE_CODE, 3'(i), 1'b0}, 1'b1, 1'b1, 1'b0);
            check(ak, 3'(i) == cs);
        end
        xfer({~`EIS_TYPE_CODE, cs, 1'b0}, 1'b1, 1'b1, 1'b0);
        check(ak, 1'b0);
        wseq(1'b0);
        xfer(adr, 1'b1, 1'b1, 1'b0);
        check(sbusy, 1'b1);
        check(ak, 1'b0);
        // Poll until the write cycle lets the address through
        k = 0;
        do begin
            xfer(adr, 1'b1, 1'b1, 1'b0);
            k++;
        end while (ak !== 1'b1 && k < 40);
        check(k > 1, 1'b1);
        check(ak, 1'b1);
        check(sbusy, 1'b0);
        check(cyc - t_wr >= WR_CYC, 1'b1);
        check(cyc - t_wr < WR_CYC + 800, 1'b1);
        @(posedge clk_i);
        wp <= 1'b1;
        wseq(1'b1);
        @(posedge clk_i);
        wp <= 1'b0;
        // A refused write launches no cycle, so ack comes at once
        xfer(adr, 1'b1, 1'b1, 1'b0);
        check(ak, 1'b1);
        xfer({adr[7:1], 1'b1}, 1'b1, 1'b0, 1'b0);
        check(ak, 1'b1);
        xfer(8'h00, 1'b0, 1'b1, 1'b1);
        check(bout, txd);
        check(n_wr, 1);
        check(n_tx, 1);
        print_verdict();
    end
endmodule // eeprom_i2c_slave_front_end_bench

// File: test/eis_monitor.sv
// Concurrent checks on the two-wire link between master and slave
`timescale 1ns/1ps
module eis_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Drive values and enables of both ends
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    // Resolved line levels
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    // Open drain: a driven line is always driven low
    property p_slave_low; sda_s_oe |-> !sda_s_o; endproperty
    a_slave_low: assert property (p_slave_low)
        else $error("slave drove data high");
    property p_master_low; scl_oe |-> !scl_o; endproperty
    a_master_low: assert property (p_master_low)
        else $error("master drove clock high");
    // Slave moves its data only while the clock is low
    property p_slave_edge; $changed(sda_s_oe) |-> !scl; endproperty
    a_slave_edge: assert property (p_slave_edge)
        else $error("slave data moved with clock high");
    // Silent for eight cycles after reset is released
    property p_quiet; $fell(rst_i) |-> !sda_s_oe [*8]; endproperty
    a_quiet: assert property (p_quiet)
        else $error("slave drove data right after reset");
    // A stop leaves the slave off the line
    property p_stop_free; scl && $rose(sda) |=> !sda_s_oe [*8]; endproperty
    a_stop_free: assert property (p_stop_free)
        else $error("slave drove data after stop");
    // A slave low bit is held for at least eight cycles once driven
    property p_drive_hold; $rose(sda_s_oe) |-> sda_s_oe [*8]; endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("slave bit too short");
    // Clock phases from the divider are never short
    property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("clock high phase too short");
    property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
    a_scl_low: assert property (p_scl_low)
        else $error("clock low phase too short");
endmodule // eis_monitor
